// ---- hdl/crbf_pkg.sv ----
// package of constants and types for the cpu register banks and flags block
package crbf_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_CPU_FLAG_WORD = 8'hD0;
  localparam logic [7:0] ADDR_MAIN_OPERAND = 8'hE0;
  localparam logic [7:0] ADDR_SECOND_OPERAND = 8'hF0;
  localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
  localparam logic [7:0] FLAG_WORD_RESET = 8'h00;
  localparam logic [7:0] MAIN_OPERAND_RESET = 8'h00;
  localparam logic [7:0] SECOND_OPERAND_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // ****************
  // flag word fields
  // ****************
  localparam int CARRY_BIT = 7;
  localparam int HALF_CARRY_BIT = 6;
  localparam int USER_ZERO_BIT = 5;
  localparam int BANK_HIGH_BIT = 4;
  localparam int BANK_LOW_BIT = 3;
  localparam int SIGNED_RANGE_BIT = 2;
  localparam int USER_ONE_BIT = 1;
  localparam int PARITY_BIT = 0;
  // ****************
  // geometry and timing
  // ****************
  localparam int NUM_BANKS = 4;
  localparam int BANK_REGS = 8;
  localparam int RAM_BYTES = 128;
  localparam int CLKS_PER_ICYCLE = 4;
  localparam int ABS_TARGET_BITS = 11;
  // ****************
  // opcodes and instruction cycle counts
  // ****************
  localparam logic [3:0] GRP_ADD = 4'h2;
  localparam logic [3:0] GRP_ADD_WITH_CARRY_IN = 4'h3;
  localparam logic [3:0] GRP_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] FORM_IMM = 4'h4;
  localparam logic [3:0] FORM_DIRECT = 4'h5;
  localparam logic [7:0] OP_BREAKPOINT = 8'hA5;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_PUSH = 8'hC0;
  localparam logic [7:0] OP_POP = 8'hD0;
  localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [4:0] AJMP_LOW = 5'h01;
  localparam logic [2:0] ICYC_SHORT = 3'h1;
  localparam logic [2:0] ICYC_LONG = 3'h2;
  localparam logic [2:0] ICYC_THREE = 3'h3;
  localparam logic [2:0] ICYC_MULDIV = 3'h5;
  // ****************
  // carriers
  // ****************
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand1;
    logic [7:0] operand2;
  } crbf_instr_t;
  typedef struct packed {
    logic [7:0] result;
    logic carry;
    logic halfCarry;
    logic signedRange;
  } crbf_alu_t;
endpackage : crbf_pkg

// ---- hdl/crbf_addsub.sv ----
// add, add with carry and subtract with borrow with their flags
module crbf_addsub
  import crbf_pkg::*;
(
  // operands
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  input wire logic subtract,
  // result
  output crbf_pkg::crbf_alu_t aluOut
);
  logic [8:0] wide;
  logic [4:0] nib;
  always_comb begin
    if (subtract) begin
      wide = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
      nib = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, carryIn};
    end else begin
      wide = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
      nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    end
    aluOut.result = wide[7:0];
    aluOut.carry = wide[8];
    aluOut.halfCarry = nib[4];
    // carry out on add, borrow on subtract, taken as printed
    aluOut.signedRange = wide[8];
  end
endmodule : crbf_addsub

// ---- hdl/cpu_register_banks_and_flags.sv ----
// cpu register banks, flag word, stack pointer and arithmetic executor
module cpu_register_banks_and_flags
  import crbf_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_BYTES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // instruction request
  input wire logic instrValid,
  input crbf_pkg::crbf_instr_t instrIn,
  output logic instrReady,
  output logic instrDone,
  output logic breakpointHit,
  // visible state
  output logic [7:0] mainOperand,
  output logic [7:0] secondOperand,
  output logic [7:0] stackPointer,
  output logic [7:0] cpuFlagWord,
  output logic [15:0] programCounter,
  output logic [1:0] activeBank
);
  import crbf_pkg::*;

  // ****************
  // sequencing
  // ****************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } crbf_state_t;

  crbf_state_t state_reg;
  crbf_state_t state_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  crbf_instr_t ins_reg;
  logic commit;
  logic take;

  logic [7:0] ram_reg [RAM_DEPTH];
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [7:0] b_reg;
  logic [7:0] b_next;
  logic [7:0] sp_reg;
  logic [7:0] sp_next;
  logic [7:1] psw_reg;
  logic [7:1] psw_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic done_reg;
  logic trap_reg;

  function automatic logic [2:0] icycles(input logic [7:0] op);
    logic [2:0] n;
    n = ICYC_SHORT;
    if (op == OP_MUL || op == OP_DIV) begin
      n = ICYC_MULDIV;
    end else if (op == OP_MOV_DIR_IMM) begin
      n = ICYC_THREE;
    end else if (op == OP_PUSH || op == OP_POP || op == OP_SJMP) begin
      n = ICYC_LONG;
    end else if (op[4:0] == AJMP_LOW) begin
      n = ICYC_LONG;
    end else if ((op[7:4] == GRP_ADD || op[7:4] == GRP_ADD_WITH_CARRY_IN || op[7:4] == GRP_SUBTRACT_WITH_BORROW)
                 && (op[3:0] == FORM_IMM || op[3:0] == FORM_DIRECT)) begin
      n = ICYC_LONG;
    end
    return n;
  endfunction : icycles

  function automatic logic [15:0] ibytes(input logic [7:0] op);
    logic [15:0] n;
    n = 16'h0001;
    if (op == OP_MOV_DIR_IMM) begin
      n = 16'h0003;
    end else if (op == OP_PUSH || op == OP_POP || op == OP_SJMP) begin
      n = 16'h0002;
    end else if (op[4:0] == AJMP_LOW) begin
      n = 16'h0002;
    end else if ((op[7:4] == GRP_ADD || op[7:4] == GRP_ADD_WITH_CARRY_IN || op[7:4] == GRP_SUBTRACT_WITH_BORROW)
                 && (op[3:0] == FORM_IMM || op[3:0] == FORM_DIRECT)) begin
      n = 16'h0002;
    end
    return n;
  endfunction : ibytes

  // back to back: a new instruction is taken in the commit cycle of the last
  assign commit = (state_reg == ST_EXEC) && (cnt_reg == 5'h00);
  assign instrReady = (state_reg == ST_IDLE) || commit;
  assign take = instrReady && instrValid;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_EXEC;
          cnt_next = 5'((8'(icycles(instrIn.opcode)) * CLKS_PER_ICYCLE) - 1);
        end
      end
      ST_EXEC: begin
        if (commit) begin
          if (take) begin
            cnt_next = 5'((8'(icycles(instrIn.opcode)) * CLKS_PER_ICYCLE) - 1);
          end else begin
            state_next = ST_IDLE;
          end
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next = 5'h00;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ins_reg <= '0;
    end else if (take) begin
      ins_reg <= instrIn;
    end
  end

  // ****************
  // operand fetch
  // ****************
  logic [7:0] op;
  logic [1:0] bank;
  logic [7:0] parity;
  logic [7:0] pswFull;
  logic [6:0] bankRegAddr;
  logic [6:0] ptrAddr;
  logic [7:0] direct1;
  logic [7:0] srcOperand;
  logic isArith;

  assign op = ins_reg.opcode;
  assign bank = {psw_reg[BANK_HIGH_BIT], psw_reg[BANK_LOW_BIT]};
  assign pswFull = {psw_reg, ^acc_reg};
  assign parity = pswFull;
  // bank n occupies bytes 8n to 8n+7
  assign bankRegAddr = 7'({bank, op[2:0]});
  // pointer is limited to the 128-byte internal ram; bit 7 is dropped
  assign ptrAddr = ram_reg[7'({bank, 2'b00, op[0]})][6:0];

  function automatic logic [7:0] readDirect(input logic [7:0] a, input logic [7:0] ramVal,
                                           input logic [7:0] accV, input logic [7:0] bV,
                                           input logic [7:0] spV, input logic [7:0] pswV);
    logic [7:0] v;
    v = 8'h00;
    if (a < SFR_BASE) begin
      v = ramVal;
    end else if (a == ADDR_MAIN_OPERAND) begin
      v = accV;
    end else if (a == ADDR_SECOND_OPERAND) begin
      v = bV;
    end else if (a == ADDR_STACK_POINTER) begin
      v = spV;
    end else if (a == ADDR_CPU_FLAG_WORD) begin
      v = pswV;
    end
    return v;
  endfunction : readDirect

  assign direct1 = readDirect(ins_reg.operand1, ram_reg[ins_reg.operand1[6:0]],
                              acc_reg, b_reg, sp_reg, parity);
  assign isArith = (op[7:4] == GRP_ADD || op[7:4] == GRP_ADD_WITH_CARRY_IN || op[7:4] == GRP_SUBTRACT_WITH_BORROW)
                   && (op[3] || op[3:2] == 2'b01);

  always_comb begin
    if (op[3]) begin
      srcOperand = ram_reg[bankRegAddr];
    end else if (op[3:0] == FORM_IMM) begin
      srcOperand = ins_reg.operand1;
    end else if (op[3:0] == FORM_DIRECT) begin
      srcOperand = direct1;
    end else begin
      srcOperand = ram_reg[ptrAddr];
    end
  end

  // ****************
  // arithmetic
  // ****************
  crbf_alu_t alu;
  logic useCarry;
  assign useCarry = (op[7:4] != GRP_ADD) && psw_reg[CARRY_BIT];

  crbf_addsub u_addsub (
    .opA(acc_reg),
    .opB(srcOperand),
    .carryIn(useCarry),
    .subtract(op[7:4] == GRP_SUBTRACT_WITH_BORROW),
    .aluOut(alu)
  );

  logic [15:0] product;
  assign product = 16'(acc_reg) * 16'(b_reg);

  // ****************
  // commit
  // ****************
  logic dirWr;
  logic [7:0] dirAddr;
  logic [7:0] dirData;
  logic ramWr;
  logic [6:0] ramAddr;
  logic [7:0] ramData;
  logic [7:0] spInc;

  assign spInc = sp_reg + 8'h01;

  always_comb begin
    acc_next = acc_reg;
    b_next = b_reg;
    sp_next = sp_reg;
    psw_next = psw_reg;
    pc_next = pc_reg + ibytes(op);
    dirWr = 1'b0;
    dirAddr = ins_reg.operand1;
    dirData = 8'h00;
    ramWr = 1'b0;
    ramAddr = 7'h00;
    ramData = 8'h00;
    if (isArith) begin
      acc_next = alu.result;
      psw_next[CARRY_BIT] = alu.carry;
      psw_next[HALF_CARRY_BIT] = alu.halfCarry;
      psw_next[SIGNED_RANGE_BIT] = alu.signedRange;
    end else if (op == OP_MUL) begin
      acc_next = product[7:0];
      b_next = product[15:8];
      psw_next[CARRY_BIT] = 1'b0;
      psw_next[SIGNED_RANGE_BIT] = (product[15:8] != 8'h00);
    end else if (op == OP_DIV) begin
      psw_next[CARRY_BIT] = 1'b0;
      psw_next[SIGNED_RANGE_BIT] = (b_reg == 8'h00);
      if (b_reg != 8'h00) begin
        acc_next = acc_reg / b_reg;
        b_next = acc_reg % b_reg;
      end
    end else if (op == OP_RLC) begin
      acc_next = {acc_reg[6:0], psw_reg[CARRY_BIT]};
      psw_next[CARRY_BIT] = acc_reg[7];
    end else if (op == OP_RRC) begin
      acc_next = {psw_reg[CARRY_BIT], acc_reg[7:1]};
      psw_next[CARRY_BIT] = acc_reg[0];
    end else if (op == OP_PUSH) begin
      sp_next = spInc;
      ramWr = 1'b1;
      ramAddr = spInc[6:0];
      ramData = direct1;
    end else if (op == OP_POP) begin
      sp_next = sp_reg - 8'h01;
      dirWr = 1'b1;
      dirData = ram_reg[sp_reg[6:0]];
    end else if (op == OP_MOV_DIR_IMM) begin
      dirWr = 1'b1;
      dirData = ins_reg.operand2;
    end else if (op == OP_SJMP) begin
      pc_next = pc_reg + 16'h0002 + {{8{ins_reg.operand1[7]}}, ins_reg.operand1};
    end else if (op[4:0] == AJMP_LOW) begin
      // the block of the following instruction is kept, so a jump never leaves it
      pc_next = {pc_next[15:ABS_TARGET_BITS], op[7:5], ins_reg.operand1};
    end
    // a direct write lands after the implicit updates, so it wins
    if (dirWr) begin
      if (dirAddr < SFR_BASE) begin
        ramWr = 1'b1;
        ramAddr = dirAddr[6:0];
        ramData = dirData;
      end else if (dirAddr == ADDR_MAIN_OPERAND) begin
        acc_next = dirData;
      end else if (dirAddr == ADDR_SECOND_OPERAND) begin
        b_next = dirData;
      end else if (dirAddr == ADDR_STACK_POINTER) begin
        sp_next = dirData;
      end else if (dirAddr == ADDR_CPU_FLAG_WORD) begin
        psw_next = dirData[7:1];
      end
    end
  end

  // ****************
  // state registers
  // ****************
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_reg <= MAIN_OPERAND_RESET;
      b_reg <= SECOND_OPERAND_RESET;
    end else if (commit) begin
      acc_reg <= acc_next;
      b_reg <= b_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sp_reg <= STACK_POINTER_RESET;
    end else if (commit) begin
      sp_reg <= sp_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      psw_reg <= FLAG_WORD_RESET[7:1];
    end else if (commit) begin
      psw_reg <= psw_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_reg <= PC_RESET;
    end else if (commit) begin
      pc_reg <= pc_next;
    end
  end

  // ram is left uninitialised by reset, as working memory normally is
  always_ff @(posedge mclk) begin
    if (commit && ramWr) begin
      ram_reg[ramAddr] <= ramData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      done_reg <= 1'b0;
      trap_reg <= 1'b0;
    end else begin
      done_reg <= commit;
      trap_reg <= commit && (op == OP_BREAKPOINT);
    end
  end

  // ****************
  // outputs
  // ****************
  assign instrDone = done_reg;
  assign breakpointHit = trap_reg;
  assign mainOperand = acc_reg;
  assign secondOperand = b_reg;
  assign stackPointer = sp_reg;
  assign cpuFlagWord = pswFull;
  assign programCounter = pc_reg;
  assign activeBank = bank;
endmodule : cpu_register_banks_and_flags

// ---- tb/crbf_regs_props.sv ----
// assertion checker for the register banks and flags block
module crbf_regs_props
  import crbf_pkg::*;
#(
  parameter int RAM_DEPTH = 128
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // instruction port
  input wire logic instrValid,
  input crbf_pkg::crbf_instr_t instrIn,
  input wire logic instrReady,
  input wire logic instrDone,
  input wire logic breakpointHit,
  // visible state
  input wire logic [7:0] mainOperand,
  input wire logic [7:0] secondOperand,
  input wire logic [7:0] stackPointer,
  input wire logic [7:0] cpuFlagWord,
  input wire logic [15:0] programCounter,
  input wire logic [1:0] activeBank
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic take;
  logic tookLast;
  logic [7:0] curOp;
  logic [7:0] prevOp;
  logic [7:0] doneOp;
  assign take = instrValid && instrReady;
  // a take in the commit cycle has already replaced the finishing opcode
  assign doneOp = tookLast ? prevOp : curOp;
  always_ff @(posedge mclk) begin
    if (rst) begin
      tookLast <= 1'h0;
      curOp <= 8'h00;
      prevOp <= 8'h00;
    end else begin
      tookLast <= take;
      if (take) begin
        prevOp <= curOp;
        curOp <= instrIn.opcode;
      end
    end
  end
  // *****
  // completion after n instruction cycles
  // *****
  sequence s_one;
    ##2 (!instrDone)[*3] ##1 instrDone;
  endsequence
  sequence s_two;
    ##2 (!instrDone)[*7] ##1 instrDone;
  endsequence
  sequence s_three;
    ##2 (!instrDone)[*8] ##1 (!instrDone)[*3] ##1 instrDone;
  endsequence
  AST_PARITY: assert property (cpuFlagWord[0] == ^mainOperand)
    else $error("parity bit does not follow main operand");
  AST_BANK: assert property (activeBank == cpuFlagWord[4:3] &&
    ($past(rst) || $stable(activeBank) || instrDone))
    else $error("active bank differs from flag word or moved outside a commit");
  AST_SP_RESET: assert property ($fell(rst) |-> stackPointer == 8'h07)
    else $error("stack pointer wrong after reset");
  AST_BUSY: assert property (take |=> (!instrReady)[*3])
    else $error("new request accepted too early");
  AST_ONE: assert property (take && instrIn.opcode inside {8'hA5, [8'h26:8'h2F],
    [8'h36:8'h3F], [8'h96:8'h9F]} |-> s_one)
    else $error("short instruction not four clocks");
  AST_TWO: assert property (take && instrIn.opcode inside {8'h24, 8'h25, 8'h34, 8'h35,
    8'h94, 8'h95, 8'hC0, 8'hD0, 8'h80} |-> s_two)
    else $error("two cycle instruction not eight clocks");
  AST_THREE: assert property (take && instrIn.opcode == 8'h75 |-> s_three)
    else $error("three cycle instruction not twelve clocks");
  AST_QUIET: assert property (!$past(rst) && $changed({mainOperand, secondOperand,
    stackPointer}) |-> instrDone)
    else $error("register changed outside a commit");
  AST_PUSH: assert property (instrDone && doneOp == 8'hC0 |->
    stackPointer == $past(stackPointer) + 8'h01)
    else $error("push did not raise stack pointer by one");
  AST_BRK: assert property ((instrDone || breakpointHit) |->
    breakpointHit == (instrDone && doneOp == 8'hA5))
    else $error("breakpoint pulse wrong");
endmodule : crbf_regs_props

bind cpu_register_banks_and_flags crbf_regs_props #(.RAM_DEPTH(RAM_DEPTH)) i_props (
  .mclk(mclk), .rst(rst), .instrValid(instrValid), .instrIn(instrIn),
  .instrReady(instrReady), .instrDone(instrDone), .breakpointHit(breakpointHit),
  .mainOperand(mainOperand), .secondOperand(secondOperand), .stackPointer(stackPointer),
  .cpuFlagWord(cpuFlagWord), .programCounter(programCounter), .activeBank(activeBank)
);

// ---- tb/tb_top.sv ----
// self-checking bench for the register banks and flags block
module tb_top
  import crbf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic instrValid = 1'h0;
  crbf_instr_t instrIn = '0;
  logic instrReady, instrDone, breakpointHit, brk;
  logic [7:0] mainOperand, secondOperand, stackPointer, cpuFlagWord;
  logic [15:0] programCounter;
  logic [1:0] activeBank;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int cyc;
  // second immediate byte, used only by the move-immediate-to-direct opcode
  logic [7:0] imm2 = 8'h00;
  always #12.5 mclk = ~mclk;
  cpu_register_banks_and_flags i_cpu_register_banks_and_flags (.mclk, .rst, .instrValid,
    .instrIn, .instrReady, .instrDone, .breakpointHit, .mainOperand, .secondOperand,
    .stackPointer, .cpuFlagWord, .programCounter, .activeBank);
  // *****
  // checking and bus tasks
  // *****
  task automatic conclude();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk16
  // entered just after a falling edge; request held until taken
  task automatic exec(input logic [7:0] op, input logic [7:0] o1, input int n);
    instrIn = {op, o1, imm2};
    instrValid = 1'h1;
    while (instrReady !== 1'h1) @(negedge mclk);
    @(negedge mclk);
    instrValid = 1'h0;
    cyc = 1;
    while (instrDone !== 1'h1 && cyc < 40) begin
      @(negedge mclk);
      cyc++;
    end
    brk = breakpointHit;
    chk16(16'(cyc), 16'(4 * n + 1));
  endtask : exec
  task automatic mov(input logic [7:0] a, input logic [7:0] d);
    imm2 = d;
    exec(8'h75, a, 3);
  endtask : mov
  // *****
  // scenarios
  // *****
  task automatic t_regs();
    chk8(stackPointer, 8'h07);
    mov(8'hE0, 8'h96);
    chk8(mainOperand, 8'h96);
    chk8(cpuFlagWord, 8'h00);
    mov(8'hE0, 8'h07);
    chk8(cpuFlagWord, 8'h01);
    mov(8'hF0, 8'h5A);
    chk8(secondOperand, 8'h5A);
  endtask : t_regs
  // user bits stay set through arithmetic, so they must not be disturbed
  task automatic t_arith(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                         input logic c);
    logic [8:0] s;
    logic h;
    logic ci;
    ci = (op[7:4] == GRP_ADD) ? 1'h0 : c;
    if (op[7:4] == GRP_SUBTRACT_WITH_BORROW) begin
      s = {1'h0, a} - b - ci;
      h = {1'h0, a[3:0]} < {1'h0, b[3:0]} + ci;
    end else begin
      s = {1'h0, a} + b + ci;
      h = {1'h0, a[3:0]} + b[3:0] + ci > 5'h0F;
    end
    mov(8'hF0, b);
    mov(8'hD0, {c, 7'h22});
    mov(8'hE0, a);
    exec(op, (op[3:0] == FORM_DIRECT) ? 8'hF0 : b, 2);
    chk8(mainOperand, s[7:0]);
    chk8(cpuFlagWord, {s[8], h, 3'h4, s[8], 1'h1, ^s[7:0]});
  endtask : t_arith
  task automatic t_bank();
    for (int k = 0; k < 4; k++) begin
      mov(8'(8 * k + 3), 8'(8'h10 + k));
      mov(8'(8 * k), 8'(8'h40 + k));
      mov(8'(8'h40 + k), 8'h20);
      mov(8'hE0, 8'h00);
      mov(8'hD0, {3'h0, 2'(k), 3'h0});
      exec(8'h2B, 8'h00, 1);
      exec(8'h26, 8'h00, 1);
      chk8(mainOperand, 8'(8'h30 + k));
      chk8({6'h00, activeBank}, 8'(k));
    end
  endtask : t_bank
  task automatic t_stack();
    mov(8'h01, 8'hAA);
    chk8(stackPointer, 8'h07);
    mov(8'h81, 8'h30);
    mov(8'hE0, 8'hC3);
    exec(8'hC0, 8'hE0, 2);
    chk8(stackPointer, 8'h31);
    mov(8'hE0, 8'h00);
    exec(8'h25, 8'h31, 2);
    chk8(mainOperand, 8'hC3);
    exec(8'hD0, 8'hF0, 2);
    chk8(secondOperand, 8'hC3);
    chk8(stackPointer, 8'h30);
  endtask : t_stack
  task automatic t_flow();
    logic [15:0] p;
    p = programCounter;
    exec(8'hA5, 8'h00, 1);
    chk8({7'h00, brk}, 8'h01);
    chk16(programCounter, p + 16'h0001);
    p = programCounter + 16'h0002;
    exec(8'h80, 8'hF0, 2);
    chk16(programCounter, p - 16'h0010);
    p = programCounter + 16'h0002;
    exec(8'h21, 8'h34, 2);
    chk16(programCounter, {p[15:11], 3'h1, 8'h34});
  endtask : t_flow
  // multiply and divide use the second operand register; divide by zero keeps both
  task automatic t_muldiv();
    mov(8'hD0, 8'h80);
    mov(8'hE0, 8'h20);
    mov(8'hF0, 8'h10);
    exec(8'hA4, 8'h00, 5);
    chk8(mainOperand, 8'h00);
    chk8(secondOperand, 8'h02);
    chk8(cpuFlagWord, 8'h04);
    mov(8'hE0, 8'h64);
    mov(8'hF0, 8'h07);
    exec(8'h84, 8'h00, 5);
    chk8(mainOperand, 8'h0E);
    chk8(secondOperand, 8'h02);
    chk8(cpuFlagWord, 8'h01);
    mov(8'hF0, 8'h00);
    exec(8'h84, 8'h00, 5);
    chk8(mainOperand, 8'h0E);
    chk8(secondOperand, 8'h00);
    chk8(cpuFlagWord, 8'h05);
    mov(8'hD0, 8'h80);
    mov(8'hE0, 8'h41);
    exec(8'h33, 8'h00, 1);
    chk8(mainOperand, 8'h83);
    chk8(cpuFlagWord, 8'h01);
    exec(8'h13, 8'h00, 1);
    chk8(mainOperand, 8'h41);
    chk8(cpuFlagWord, 8'h80);
  endtask : t_muldiv
  // a mid-run reset must restore every visible register and the idle handshake
  task automatic t_reset();
    rst = 1'h1;
    repeat (3) @(negedge mclk);
    rst = 1'h0;
    chk8(stackPointer, 8'h07);
    chk8(mainOperand, 8'h00);
    chk8(secondOperand, 8'h00);
    chk8(cpuFlagWord, 8'h00);
    chk16(programCounter, 16'h0000);
    chk8({7'h00, instrReady}, 8'h01);
    mov(8'hE0, 8'h3C);
    chk8(mainOperand, 8'h3C);
  endtask : t_reset
  // the whole run needs about 975 cycles, roughly a quarter of the 4000-cycle limit
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'h0;
    t_regs();
    t_arith(8'h24, 8'h0F, 8'h01, 1'h1);
    t_arith(8'h25, 8'hFF, 8'h01, 1'h0);
    t_arith(8'h34, 8'h7F, 8'h80, 1'h1);
    t_arith(8'h35, 8'h10, 8'h20, 1'h0);
    t_arith(8'h94, 8'h10, 8'h01, 1'h1);
    t_arith(8'h95, 8'h05, 8'h05, 1'h1);
    t_arith(8'h94, 8'h50, 8'h20, 1'h0);
    t_bank();
    t_stack();
    t_flow();
    t_muldiv();
    t_reset();
    conclude();
  end
endmodule : tb_top
